// ==== core/psfl_fault_latch.sv ====
// Latching fault aggregator and firing inhibit for a three-phase power stage
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Five fault categories: four live-side, one isolated-side Hall trip.
// [RULE2] Every fault is latched; any set latch inhibits all firing.
// [RULE3] Live faults OR active-high into one signal forcing inverter shutdown.
// [RULE4] Combined live fault also suppresses PFC and brake chopper firing.
// [RULE5] Combined live fault drives a live-fault indication to isolated side.
// [RULE6] Hall over-current blocks every firing path.
// [RULE7] Isolated and live faults merge into one active-low fault output.
// [RULE8] Latches are set-dominant; a fault wins over an active clear.
// [RULE9] Inverter leg shunt trips respond only to positive current.
// [RULE10] DC bus shunt trip responds to negative bus current.
// [RULE11] A latched fault lights the visual fault indicator.
// [RULE12] DC bus over-voltage latches and shuts down like shunt over-current.
// [RULE13] Brake over-current latches and shuts down like shunt over-current.
// [RULE14] Heat sink over-temperature latches and shows like shunt over-current.
// [RULE15] Output Hall trips respond to positive and negative over-current.
// [RULE16] DC input Hall trip responds only to positive over-current.
// [RULE17] Processor pulses clear after all fault conditions have gone away.
module psfl_fault_latch
    import psfl_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    input  wire psfl_trip_t               trip_pin,
    input  wire logic                     clear_n_pin,
    input  wire psfl_fire_t               fire_cmd,
    output psfl_fire_t                    fire_out,
    output logic                          inv_shutdown,
    output logic                          live_fault_iso,
    output logic                          fault_n,
    output logic                          fault_led,
    output logic [PSFL_NUM_FLT-1:0]       fault_latched
);

    typedef struct packed {
        logic [PSFL_NUM_FLT-1:0] latch;
        psfl_fire_t              fire;
        logic                    inv_sd;
        logic                    live_iso;
        logic                    fault_n;
        logic                    led;
    } psfl_state_t;

    psfl_state_t                state;
    psfl_state_t                next_state;
    psfl_trip_t                 trip;
    logic                       clear_n;
    logic [PSFL_NUM_FLT-1:0]    cond;
    logic [PSFL_NUM_FLT-1:0]    next_latch;
    logic                       live_any;
    logic                       any_fault;

    // Pins come from analog comparators, so they are brought onto clk_sys
    psfl_sync #(
        .WIDTH (PSFL_TRIP_W + 1)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .pin     ({trip_pin, clear_n_pin}),
        .level   ({trip, clear_n})
    );

    always_comb begin
        cond = '0;
        cond[PSFL_FLT_SHUNT]   = |trip.leg_pos_oc                    // [RULE9]
                               | trip.bus_neg_oc;                   // [RULE10]
        cond[PSFL_FLT_BUS_OV]  = trip.bus_ov;                       // [RULE12]
        cond[PSFL_FLT_BRAKE]   = trip.brake_oc;                     // [RULE13]
        cond[PSFL_FLT_THERMAL] = trip.sink_ot;                      // [RULE14]
        cond[PSFL_FLT_HALL]    = |trip.out_pos_oc | |trip.out_neg_oc // [RULE15]
                               | trip.in_pos_oc;                    // [RULE16]
    end

    // Set dominates clear so a fault holds even with clear held low
    always_comb begin
        for (int i = 0; i < PSFL_NUM_FLT; i++) begin
            next_latch[i] = cond[i] | (state.latch[i] & clear_n);  // [RULE8] [RULE2] [RULE1]
        end
    end

    // Gating works from the fresh latch value plus the raw condition so a
    // trip reaches the gates one cycle after synchronisation, not two
    always_comb begin
        live_any  = |next_latch[PSFL_NUM_LIVE-1:0];                 // [RULE3]
        any_fault = live_any | next_latch[PSFL_FLT_HALL];
    end

    always_comb begin
        next_state          = state;
        next_state.latch    = next_latch;
        next_state.inv_sd   = live_any;                             // [RULE3]
        next_state.live_iso = live_any;                             // [RULE5]
        next_state.fault_n  = ~any_fault;                           // [RULE7]
        next_state.led      = any_fault;                            // [RULE11]
        next_state.fire     = fire_cmd;
        if (live_any) begin
            next_state.fire.inv   = PSFL_INV_GATES;                 // [RULE3]
            next_state.fire.pfc   = 1'b0;                           // [RULE4]
            next_state.fire.brake = 1'b0;                           // [RULE4]
        end
        if (next_latch[PSFL_FLT_HALL]) begin
            next_state.fire = '0;                                   // [RULE6]
        end
    end

    // Reset leaves firing blocked but no fault reported
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state         <= '0;
            state.latch   <= PSFL_LATCH_RST;
            state.fault_n <= 1'b1;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign fire_out       = state.fire;
    assign inv_shutdown   = state.inv_sd;
    assign live_fault_iso = state.live_iso;
    assign fault_n        = state.fault_n;
    assign fault_led      = state.led;
    assign fault_latched  = state.latch;

endmodule // psfl_fault_latch

// ==== core/psfl_pkg.sv ====
// Package for the power stage fault latch: types and constants
package psfl_pkg;

    // Synchroniser depth for pin inputs
    localparam int PSFL_SYNC_STAGES = 3;

    // Fault categories, index into the latch vector
    localparam int PSFL_FLT_SHUNT   = 0;
    localparam int PSFL_FLT_BUS_OV  = 1;
    localparam int PSFL_FLT_BRAKE   = 2;
    localparam int PSFL_FLT_THERMAL = 3;
    localparam int PSFL_FLT_HALL    = 4;
    localparam int PSFL_NUM_FLT     = 5;
    localparam int PSFL_NUM_LIVE    = 4;

    // Latch reset value and inverter gate value forced on a live fault
    localparam logic [4:0] PSFL_LATCH_RST = 5'h00;
    localparam logic [2:0] PSFL_INV_GATES = 3'h0;

    // Raw comparator trips from the sensing front ends
    typedef struct packed {
        logic [2:0] leg_pos_oc;   // Inverter leg shunt, positive current
        logic       bus_neg_oc;   // DC bus shunt, negative current
        logic       bus_ov;       // DC bus over-voltage
        logic       brake_oc;     // Brake chopper over-current
        logic       sink_ot;      // Heat sink over-temperature
        logic [1:0] out_pos_oc;   // Output Hall sensors, positive
        logic [1:0] out_neg_oc;   // Output Hall sensors, negative
        logic       in_pos_oc;    // DC input Hall sensor, positive
    } psfl_trip_t;

    // Firing commands from the processor
    typedef struct packed {
        logic [5:0] inv;          // Six inverter gates
        logic       pfc;
        logic       brake;
    } psfl_fire_t;

    localparam int PSFL_TRIP_W = $bits(psfl_trip_t);
    localparam int PSFL_FIRE_W = $bits(psfl_fire_t);
    localparam logic [PSFL_TRIP_W-1:0] PSFL_TRIP_RST = '0;

endpackage

// ==== core/psfl_sync.sv ====
// Three-stage synchroniser with agreement filter for a bus of pins
`timescale 1ns/1ps
module psfl_sync
    import psfl_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } psfl_sync_state_t;

    psfl_sync_state_t state;
    psfl_sync_state_t next_state;

    always_comb begin
        next_state    = state;
        next_state.s1 = pin;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // A change counts only once the second and third stages agree
        for (int i = 0; i < WIDTH; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.lvl[i] = state.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign level = state.lvl;

endmodule // psfl_sync

// ==== dv/psfl_props.sv ====
// Port assertions for the power stage fault latch
`timescale 1ns/1ps
module psfl_props
    import psfl_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              clk_en,
    input wire psfl_trip_t        trip_pin,
    input wire logic              clear_n_pin,
    input wire psfl_fire_t        fire_cmd,
    input wire psfl_fire_t        fire_out,
    input wire logic              inv_shutdown,
    input wire logic              live_fault_iso,
    input wire logic              fault_n,
    input wire logic              fault_led,
    input wire logic [4:0]        fault_latched
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_fault_merge: assert property (fault_n != (|fault_latched))
        else $error("fault_n does not match latches");
    chk_led_show: assert property (fault_led == (|fault_latched))
        else $error("fault_led does not match latches");
    chk_live_shut: assert property (inv_shutdown == (|fault_latched[3:0]))
        else $error("inv_shutdown does not match live latches");
    chk_live_iso: assert property (live_fault_iso == inv_shutdown)
        else $error("live_fault_iso differs from inv_shutdown");
    chk_fire_block: assert property ((|fault_latched) |-> fire_out == '0)
        else $error("firing while a latch is set");
    chk_live_gate: assert property (inv_shutdown |-> !fire_out.pfc && !fire_out.brake)
        else $error("pfc or brake fired in live fault");
    chk_fire_pass: assert property ($past(reset_n) && $past(clk_en) && !(|fault_latched)
        |-> fire_out == $past(fire_cmd)) else $error("fire_out not last fire_cmd");
    chk_hall_block: assert property ((|trip_pin[4:0] && clk_en)[*6]
        |-> fault_latched[4] && fire_out == '0) else $error("hall trip not blocking");
    chk_heat_set: assert property ((trip_pin.sink_ot && clk_en)[*6]
        |-> fault_latched[3]) else $error("thermal trip not latched");
    chk_clear_hold: assert property (clear_n_pin[*6] |=> !$fell(|fault_latched))
        else $error("latch dropped without clear");
endmodule // psfl_props
bind psfl_fault_latch psfl_props u_psfl_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(clk_en), .trip_pin(trip_pin), .clear_n_pin(clear_n_pin), .fire_cmd(fire_cmd),
    .fire_out(fire_out), .inv_shutdown(inv_shutdown), .live_fault_iso(live_fault_iso),
    .fault_n(fault_n), .fault_led(fault_led), .fault_latched(fault_latched));

// ==== dv/psfl_cpu_model.sv ====
// Processor-side model: rotating firing commands and latch clear
`timescale 1ns/1ps
module psfl_cpu_model
    import psfl_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  clear_req,
    output psfl_fire_t fire_cmd,
    output logic       clear_n_pin
);
    initial begin
        fire_cmd    = 8'hA5;
        clear_n_pin = 1'b1;
    end
    // Pattern changes every cycle so a stale fire_out cannot pass
    always @(posedge clk_sys) begin
        fire_cmd    <= {fire_cmd[6:0], fire_cmd[7]};
        clear_n_pin <= !clear_req;
    end
endmodule // psfl_cpu_model

// ==== dv/testbench.sv ====
// Self-checking bench for the power stage fault latch
`timescale 1ns/1ps
module testbench;
    import psfl_pkg::*;
    logic       clk_sys, reset_n, clk_en, clear_req, clear_n_pin;
    logic       inv_shutdown, live_fault_iso, fault_n, fault_led;
    psfl_trip_t trip_pin;
    psfl_fire_t fire_cmd, fire_out, prev_cmd;
    logic [4:0] fault_latched;
    int         miscompares = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    psfl_fault_latch u_psfl_fault_latch (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .trip_pin(trip_pin), .clear_n_pin(clear_n_pin), .fire_cmd(fire_cmd), .fire_out(fire_out),
        .inv_shutdown(inv_shutdown), .live_fault_iso(live_fault_iso), .fault_n(fault_n),
        .fault_led(fault_led), .fault_latched(fault_latched));
    psfl_cpu_model u_psfl_cpu_model (.clk_sys(clk_sys), .clear_req(clear_req),
        .fire_cmd(fire_cmd), .clear_n_pin(clear_n_pin));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        prev_cmd <= fire_cmd;
        cycles   <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic test_trip(input int b);
        int cat;
        cat = (b >= 8) ? 0 : (b >= 5) ? 8 - b : 4;
        @(posedge clk_sys);
        trip_pin  <= 12'h001 << b;
        clear_req <= 1'b1; // Clear held meanwhile: the trip must still win
        wait_cyc(8);
        check("fault_latched", 8'(fault_latched), 8'h01 << cat);
        check("fire_out", fire_out, 8'h00);
        check("inv_shutdown", 8'(inv_shutdown), 8'(cat < 4));
        check("live_fault_iso", 8'(live_fault_iso), 8'(cat < 4));
        check("fault_n", 8'(fault_n), 8'h00);
        check("fault_led", 8'(fault_led), 8'h01);
        // Clear goes away first: its path is one flop longer than the trip path
        @(posedge clk_sys);
        clear_req <= 1'b0;
        wait_cyc(8);
        @(posedge clk_sys);
        trip_pin  <= '0;
        wait_cyc(8);
        check("held latch", 8'(fault_latched), 8'h01 << cat);
        @(posedge clk_sys);
        clear_req <= 1'b1;
        wait_cyc(8);
        @(posedge clk_sys);
        clear_req <= 1'b0;
        wait_cyc(2);
        check("cleared latch", 8'(fault_latched), 8'h00);
        check("fire_out free", fire_out, prev_cmd);
        $display("test_trip %0d done", b);
    endtask
    task automatic test_freeze();
        psfl_fire_t held;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wait_cyc(1);
        held = fire_out;
        @(posedge clk_sys);
        trip_pin <= 12'h001;
        wait_cyc(8);
        check("frozen fire_out", fire_out, held);
        check("frozen latch", 8'(fault_latched), 8'h00);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        wait_cyc(8);
        check("hall after run", 8'(fault_latched), 8'h10);
        check("hall fire_out", fire_out, 8'h00);
        @(posedge clk_sys);
        trip_pin <= '0;
        wait_cyc(8);
        @(posedge clk_sys);
        clear_req <= 1'b1;
        wait_cyc(8);
        @(posedge clk_sys);
        clear_req <= 1'b0;
        wait_cyc(2);
        check("freeze cleared", 8'(fault_latched), 8'h00);
        $display("test_freeze done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        reset_n   = 1'b0;
        clk_en    = 1'b1;
        clear_req = 1'b0;
        trip_pin  = '0;
        wait_cyc(11);
        check("reset fire_out", fire_out, 8'h00);
        check("reset fault_n", 8'(fault_n), 8'h01);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_cyc(3);
        check("fire_out pass", fire_out, prev_cmd);
        $display("test_reset done");
        for (int b = 0; b < 12; b++) begin
            test_trip(b);
        end
        test_freeze();
        close_out();
    end
endmodule // testbench
